//--- logic/bfu_core.sv
`default_nettype none
// Contract
// - Rotate left through carry, flags ZCNVS
// - Rotate right through carry, flags ZCNVS
// - Selected bit copied into transfer flag
// - Transfer flag copied into selected bit
// - Set or clear overflow only
// - Set or clear half carry only
// - Set or clear signed flag only
// - Sleep pulses sleep logic, flags kept
// - Watchdog restart pulse, flags kept
// - Break signals debug only when enabled
module bfu_core
(
   input  wire logic              CLOCK_I,
   input  wire logic              RST_N_I,
   input  wire logic              CLK_EN_I,
   input  wire logic              DEBUG_EN_I,
   input  wire bfu_pkg::bfu_wb_req_type WB_REQ_I,
   output var  bfu_pkg::bfu_wb_rsp_type WB_RSP_O,
   output logic                   SLEEP_REQ_O,
   output logic                   WDT_RESTART_O,
   output logic                   DEBUG_BREAK_O
);
   import bfu_pkg::*;

   logic [7:0]     status_reg, status_next;
   logic [7:0]     result_reg, result_next;
   logic [2:0]     event_reg, event_next;
   logic           ack_reg, ack_next;
   logic [31:0]    rdat_reg, rdat_next;
   logic           sleep_reg, sleep_next;
   logic           wdt_reg, wdt_next;
   logic           brk_reg, brk_next;

   logic           req;
   logic           cmd_wr;
   logic [7:0]     opd;
   logic [2:0]     bsel;
   bfu_op_type     op;

   // Ack only on a fresh request; ack_reg high blocks a double answer
   assign req    = WB_REQ_I.cyc && WB_REQ_I.stb && !ack_reg;
   assign cmd_wr = req && WB_REQ_I.we && (WB_REQ_I.adr == ADR_CMD) && (&WB_REQ_I.sel[1:0]);
   assign opd    = WB_REQ_I.dat[7:0];
   assign bsel   = WB_REQ_I.dat[CMD_BIT_LSB +: 3];
   assign op     = bfu_op_type'(WB_REQ_I.dat[CMD_OP_LSB +: 4]);

   always_comb
   begin
      logic [7:0] r;
      logic       nf;
      logic       shift_op;
      r           = result_reg;
      shift_op    = 1'b0;
      nf          = 1'b0;
      status_next = status_reg;
      result_next = result_reg;
      event_next  = event_reg;
      sleep_next  = 1'b0;
      wdt_next    = 1'b0;
      brk_next    = 1'b0;
      if (cmd_wr)
      begin
         case (op)
            OP_ROTATE_LEFT_CARRY:
            begin
               r = {opd[6:0], status_reg[FLAG_C]};
               status_next[FLAG_C] = opd[7];
               shift_op = 1'b1;
            end
            OP_ROTATE_RIGHT_CARRY:
            begin
               r = {status_reg[FLAG_C], opd[7:1]};
               status_next[FLAG_C] = opd[0];
               shift_op = 1'b1;
            end
            OP_LOGICAL_SHIFT_RIGHT:
            begin
               r = {1'b0, opd[7:1]};
               status_next[FLAG_C] = opd[0];
               shift_op = 1'b1;
            end
            OP_ARITHMETIC_SHIFT_RIGHT:
            begin
               r = {opd[7], opd[7:1]};
               status_next[FLAG_C] = opd[0];
               shift_op = 1'b1;
            end
            OP_SWAP_NIBBLES:
            begin
               r = {opd[3:0], opd[7:4]};
            end
            OP_BIT_TO_TRANSFER_FLAG:
            begin
               status_next[FLAG_T] = opd[bsel];
            end
            OP_TRANSFER_FLAG_TO_BIT:
            begin
               r = opd;
               r[bsel] = status_reg[FLAG_T];
            end
            OP_FLAG_SET:
            begin
               status_next[bsel] = 1'b1;
            end
            OP_FLAG_CLEAR:
            begin
               status_next[bsel] = 1'b0;
            end
            OP_SLEEP:
            begin
               sleep_next = 1'b1;
               event_next[0] = 1'b1;
            end
            OP_WATCHDOG_RESTART:
            begin
               wdt_next = 1'b1;
               event_next[1] = 1'b1;
            end
            OP_BREAK:
            begin
               if (DEBUG_EN_I)
               begin
                  brk_next = 1'b1;
                  event_next[2] = 1'b1;
               end
            end
            default:
            begin
            end
         endcase
         result_next = r;
         if (shift_op)
         begin
            nf = r[7];
            status_next[FLAG_Z] = (r == 8'h00);
            status_next[FLAG_N] = nf;
            status_next[FLAG_V] = nf ^ status_next[FLAG_C];
            status_next[FLAG_S] = nf ^ (nf ^ status_next[FLAG_C]);
         end
      end
      // Status write from software; event flags clear by writing ones
      if (req && WB_REQ_I.we && WB_REQ_I.sel[0])
      begin
         if (WB_REQ_I.adr == ADR_STATUS)
         begin
            status_next = WB_REQ_I.dat[7:0];
         end
         if (WB_REQ_I.adr == ADR_EVENT)
         begin
            // Set wins: a same-cycle event is kept
            event_next = (event_reg & ~WB_REQ_I.dat[2:0]) | (event_next & ~event_reg);
         end
      end
   end

   always_comb
   begin
      ack_next  = req;
      rdat_next = 32'h0000_0000;
      if (req && !WB_REQ_I.we)
      begin
         case (WB_REQ_I.adr)
            ADR_STATUS: rdat_next = {24'h00_0000, status_reg};
            ADR_RESULT: rdat_next = {24'h00_0000, result_reg};
            ADR_EVENT:  rdat_next = {29'h0000_0000, event_reg};
            default:    rdat_next = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge CLOCK_I)
   begin
      if (!RST_N_I)
      begin
         status_reg <= STATUS_RESET;
         result_reg <= 8'h00;
         event_reg  <= 3'h0;
         ack_reg    <= 1'b0;
         rdat_reg   <= 32'h0000_0000;
         sleep_reg  <= 1'b0;
         wdt_reg    <= 1'b0;
         brk_reg    <= 1'b0;
      end
      else if (CLK_EN_I)
      begin
         status_reg <= status_next;
         result_reg <= result_next;
         event_reg  <= event_next;
         ack_reg    <= ack_next;
         rdat_reg   <= rdat_next;
         sleep_reg  <= sleep_next;
         wdt_reg    <= wdt_next;
         brk_reg    <= brk_next;
      end
   end

   assign WB_RSP_O.ack  = ack_reg;
   assign WB_RSP_O.dat  = rdat_reg;
   assign SLEEP_REQ_O   = sleep_reg;
   assign WDT_RESTART_O = wdt_reg;
   assign DEBUG_BREAK_O = brk_reg;
endmodule // bfu_core
`default_nettype wire

//--- logic/bfu_pkg.sv
`default_nettype none
package bfu_pkg;
   // Status register bit positions
   localparam int FLAG_C = 0;
   localparam int FLAG_Z = 1;
   localparam int FLAG_N = 2;
   localparam int FLAG_V = 3;
   localparam int FLAG_S = 4;
   localparam int FLAG_H = 5;
   localparam int FLAG_T = 6;
   localparam int FLAG_I = 7;
   localparam logic [7:0] STATUS_RESET = 8'h00;

   // Wishbone register map (byte addresses)
   localparam logic [3:0] ADR_CMD    = 4'h0;
   localparam logic [3:0] ADR_STATUS = 4'h4;
   localparam logic [3:0] ADR_RESULT = 4'h8;
   localparam logic [3:0] ADR_EVENT  = 4'hc;
   // Command word layout: [7:0] operand, [10:8] bit select, [15:12] opcode
   localparam int CMD_BIT_LSB = 8;
   localparam int CMD_OP_LSB  = 12;

   typedef enum logic [3:0] {
      OP_NOP, OP_ROTATE_LEFT_CARRY, OP_ROTATE_RIGHT_CARRY, OP_LOGICAL_SHIFT_RIGHT,
      OP_ARITHMETIC_SHIFT_RIGHT, OP_SWAP_NIBBLES, OP_BIT_TO_TRANSFER_FLAG,
      OP_TRANSFER_FLAG_TO_BIT, OP_FLAG_SET, OP_FLAG_CLEAR, OP_SLEEP,
      OP_WATCHDOG_RESTART, OP_BREAK
   } bfu_op_type;

   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [3:0]  adr;
      logic [3:0]  sel;
      logic [31:0] dat;
   } bfu_wb_req_type;

   typedef struct packed {
      logic        ack;
      logic [31:0] dat;
   } bfu_wb_rsp_type;
endpackage : bfu_pkg
`default_nettype wire

//--- bench/bfu_core_props.sv
`default_nettype none
module bfu_core_props
(
   input wire logic                    CLOCK_I,
   input wire logic                    RST_N_I,
   input wire logic                    CLK_EN_I,
   input wire logic                    DEBUG_EN_I,
   input wire bfu_pkg::bfu_wb_req_type WB_REQ_I,
   input wire bfu_pkg::bfu_wb_rsp_type WB_RSP_O,
   input wire logic                    SLEEP_REQ_O,
   input wire logic                    WDT_RESTART_O,
   input wire logic                    DEBUG_BREAK_O
);
   import bfu_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge CLOCK_I); endclocking
   default disable iff (!RST_N_I);
   wire logic ack = WB_RSP_O.ack;
   wire logic [3:0] op = WB_REQ_I.dat[15:12];
   sequence s_take;
      CLK_EN_I && WB_REQ_I.cyc && WB_REQ_I.stb && !ack;
   endsequence
   sequence s_cmd(logic [3:0] code);
      s_take ##0 (WB_REQ_I.we && WB_REQ_I.adr == ADR_CMD && WB_REQ_I.sel[1:0] == 2'b11
         && op == code);
   endsequence
   a_ack_after_take: assert property (s_take |=> ack)
      else $error("no ack after request");
   a_ack_one_shot: assert property (ack && CLK_EN_I |=> !ack)
      else $error("ack held too long");
   a_ack_unasked: assert property (CLK_EN_I && !WB_REQ_I.cyc |=> !ack)
      else $error("ack without request");
   a_sleep_issue: assert property (s_cmd(4'ha) |=> SLEEP_REQ_O ##1 !SLEEP_REQ_O)
      else $error("sleep pulse wrong");
   a_sleep_cause: assert property (SLEEP_REQ_O |-> ack && $past(op) == 4'ha)
      else $error("sleep pulse unasked");
   a_wdt_issue: assert property (s_cmd(4'hb) |=> WDT_RESTART_O ##1 !WDT_RESTART_O)
      else $error("restart pulse wrong");
   a_wdt_cause: assert property (WDT_RESTART_O |-> ack && $past(op) == 4'hb)
      else $error("restart pulse unasked");
   a_break_gate: assert property (s_cmd(4'hc) |=> DEBUG_BREAK_O == $past(DEBUG_EN_I))
      else $error("break not gated by debug enable");
   a_enable_freeze: assert property (!CLK_EN_I |=> $stable(WB_RSP_O) && $stable(SLEEP_REQ_O)
      && $stable(WDT_RESTART_O) && $stable(DEBUG_BREAK_O))
      else $error("outputs moved while clock enable low");
endmodule // bfu_core_props
`default_nettype wire

//--- bench/bfu_decoder_model.sv
`default_nettype none
module bfu_decoder_model
(
   input wire logic                    clk_i,
   input wire bfu_pkg::bfu_wb_rsp_type rsp_i,
   output var bfu_pkg::bfu_wb_req_type req_o
);
   import bfu_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   initial req_o = '0;
   // Request stays put until ack is sampled, so no access is taken twice
   task automatic xfer(input logic we, input logic [3:0] adr,
                       input logic [31:0] wd, output logic [7:0] rd);
      @(posedge clk_i);
      req_o <= '{1'b1, 1'b1, we, adr, 4'hf, wd};
      @(posedge clk_i);
      while (rsp_i.ack !== 1'b1)
         @(posedge clk_i);
      rd = rsp_i.dat[7:0];
      req_o <= '0;
   endtask
endmodule // bfu_decoder_model
`default_nettype wire

//--- bench/bfu_core_bench.sv
`default_nettype none
module bfu_core_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import bfu_pkg::*;
   logic           clock = 1'b0;
   logic           rst_n = 1'b0;
   logic           debug_en = 1'b0;
   logic           clk_en = 1'b1;
   bfu_wb_req_type req;
   bfu_wb_rsp_type rsp;
   int             miscompares = 0;
   int             num_checks = 0;
   // Status in, command, result and status expected
   logic [39:0] tbl [16] = '{
      40'h01_1080_01_19, 40'h00_2001_00_1b, 40'h60_3081_40_79, 40'h00_4082_c1_0c,
      40'h5a_503c_c3_5a, 40'h00_6520_c3_40, 40'h40_7700_80_40, 40'h00_8300_80_08,
      40'hff_9300_80_f7, 40'h00_8500_80_20, 40'hff_9500_80_df, 40'h00_8400_80_10,
      40'hff_9400_80_ef, 40'ha5_a000_80_a5, 40'ha5_b000_80_a5, 40'ha5_c000_80_a5};
   bfu_core i_dut (.CLOCK_I(clock), .RST_N_I(rst_n), .CLK_EN_I(clk_en), .DEBUG_EN_I(debug_en),
      .WB_REQ_I(req), .WB_RSP_O(rsp), .SLEEP_REQ_O(), .WDT_RESTART_O(), .DEBUG_BREAK_O());
   bfu_decoder_model i_dec (.clk_i(clock), .rsp_i(rsp), .req_o(req));
   initial forever #10 clock = ~clock;
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      logic [7:0] r;
      i_dec.xfer(1'b1, a, {16'h0000, d}, r);
   endtask
   task automatic chk(input string n, input logic [7:0] e, input logic [3:0] a);
      logic [7:0] r;
      i_dec.xfer(1'b0, a, 32'h0, r);
      num_checks++;
      if (r !== e)
      begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", n, e, r);
      end
   endtask
   task automatic tally_and_finish;
      if (miscompares == 0 && num_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial
   begin
      repeat (16) @(posedge clock);
      rst_n <= 1'b1;
      chk("status", 8'h00, ADR_STATUS);
      debug_en <= 1'b1;
      foreach (tbl[i])
      begin
         wr(ADR_STATUS, {8'h00, tbl[i][39:32]});
         wr(ADR_CMD, tbl[i][31:16]);
         chk("result", tbl[i][15:8], ADR_RESULT);
         chk("status", tbl[i][7:0], ADR_STATUS);
      end
      chk("event", 8'h07, ADR_EVENT);
      wr(ADR_EVENT, 16'h0007);
      debug_en <= 1'b0;
      wr(ADR_CMD, 16'hc000);
      chk("event", 8'h00, ADR_EVENT);
      chk("unmapped", 8'h00, 4'h2);
      // Request pending while frozen must wait, then land once enable returns
      clk_en <= 1'b0;
      fork
         begin
            repeat (5) @(posedge clock);
            clk_en <= 1'b1;
         end
      join_none
      wr(ADR_STATUS, 16'h00a5);
      chk("status", 8'ha5, ADR_STATUS);
      tally_and_finish();
   end
   initial
   begin
      repeat (1000) @(posedge clock);
      miscompares++;
      tally_and_finish();
   end
endmodule // bfu_core_bench
bind bfu_core bfu_core_props i_props (.CLOCK_I, .RST_N_I, .CLK_EN_I, .DEBUG_EN_I,
   .WB_REQ_I, .WB_RSP_O, .SLEEP_REQ_O, .WDT_RESTART_O, .DEBUG_BREAK_O);
`default_nettype wire
